// ---- rtl/vslc_regs.sv ----
// Luma, scaling and misc control register bank with field-selected outputs
//
// Contract
// R1: Active width is 10 bits; low byte resets 0x80, upper two from size reg.
// R2: Even and odd active-width low byte copies at 0x01C and 0x09C.
// R3: 16-bit horizontal ratio from high/low bytes, reset 0x02 and 0xAC.
// R4: Signed 8-bit luma offset added to every luma sample; zero is no change.
// R5: Notch filter used when control bit 7 is zero, bypassed when one.
// R6: Software should bypass the notch for monochrome sources.
// R7: Bit 6 one selects Y/C and no notch; zero selects composite, no chroma ADC.
// R8: Bit 5 zero enables luma decimation, one skips it; resets to one.
// R9: Bit 4 one inverts the blue/red difference output order.
// R10: Software writes only zero to reserved control bit 3.
// R11: Control bit 2 is the luma gain top bit.
// R12: Control bit 1 is the U gain top bit, bit 0 the V gain top bit.
// R13: Each misc control copy resets to 0x20.
// R14: Luma gain is 9 bits, top bit plus low byte, multiplying each luma.
// R15: Size register bits 1:0 hold the active width top two bits.
// R16: Active pixels start being output at the fall of the line sync pulse.
// R17: Even field uses even copies, odd field uses odd copies.
// R18: Every register reads back what was written, reads have no effect.
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`include "vslc_map.svh"

module vslc_regs #(
  parameter int ADDR_W = `VSLC_ADDR_W
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic odd_field,
  input wire logic line_sync_pulse,
  input wire logic [7:0] luma_in,
  input wire logic luma_in_valid,
  output logic [7:0] luma_out,
  output logic luma_out_valid,
  output logic line_active_start,
  output vslc_pkg::vslc_path_cfg_type path_cfg
);

  // --------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------
  // The map uses byte offsets up to 0xAC, which need 8 address bits
  if (ADDR_W < 8) begin : g_bad_width
    $error("vslc_regs: ADDR_W must be at least 8");
  end

  // Field positions must sit inside the 8-bit control byte
  if (`VSLC_BIT_NOTCH_DISABLE > 7 || `VSLC_BIT_COMPONENT > 7 ||
      `VSLC_BIT_LUMA_DECIM_DISABLE > 7 ||
      `VSLC_BIT_CHROMA_ORDER_INVERT > 7) begin : g_bad_field
    $error("vslc_regs: control field out of range");
  end

  // Odd copies must sit exactly 0x80 above the even ones
  localparam logic [7:0] ODD_STEP =
    `VSLC_ODD_ACTIVE_WIDTH_LOW - `VSLC_EVEN_ACTIVE_WIDTH_LOW;
  if (ODD_STEP != 8'h80) begin : g_bad_map
    $error("vslc_regs: odd copies must sit 0x80 above even ones");
  end

  // --------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------
  // Per-field copies
  vslc_pkg::vslc_field_regs_type even_regs;
  vslc_pkg::vslc_field_regs_type odd_regs;
  // Shared registers, one copy for both fields
  logic [7:0] luma_offset;
  logic [7:0] luma_gain_low;
  logic [7:0] u_gain_low;
  logic [7:0] v_gain_low;
  // Line sync history for the edge detector
  logic sync_prev;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  // Upper address bits beyond the map must be zero to hit a register
  wire logic [7:0] a8 = reg_addr[7:0];
  wire logic hi_zero = (reg_addr >> 8) == '0;
  wire logic hit_e_aw = hi_zero && a8 == `VSLC_EVEN_ACTIVE_WIDTH_LOW; // R2
  wire logic hit_e_rh = hi_zero && a8 == `VSLC_EVEN_HORIZ_RATIO_HIGH;
  wire logic hit_e_rl = hi_zero && a8 == `VSLC_EVEN_HORIZ_RATIO_LOW;
  wire logic hit_e_mc = hi_zero && a8 == `VSLC_EVEN_MISC_CONFIG;
  wire logic hit_e_su = hi_zero && a8 == `VSLC_EVEN_SIZE_UPPER_BITS;
  wire logic hit_o_aw = hi_zero && a8 == `VSLC_ODD_ACTIVE_WIDTH_LOW; // R2
  wire logic hit_o_rh = hi_zero && a8 == `VSLC_ODD_HORIZ_RATIO_HIGH;
  wire logic hit_o_rl = hi_zero && a8 == `VSLC_ODD_HORIZ_RATIO_LOW;
  wire logic hit_o_mc = hi_zero && a8 == `VSLC_ODD_MISC_CONFIG;
  wire logic hit_o_su = hi_zero && a8 == `VSLC_ODD_SIZE_UPPER_BITS;
  wire logic hit_lo = hi_zero && a8 == `VSLC_LUMA_OFFSET;
  wire logic hit_lg = hi_zero && a8 == `VSLC_LUMA_GAIN_LOW;
  wire logic hit_ug = hi_zero && a8 == `VSLC_U_GAIN_LOW;
  wire logic hit_vg = hi_zero && a8 == `VSLC_V_GAIN_LOW;

  // --------------------------------------------------------------------
  // Write enables
  // --------------------------------------------------------------------
  // Even copies; a strobe to an unmapped address touches nothing
  wire logic we_e_aw = reg_wr && hit_e_aw;
  wire logic we_e_rh = reg_wr && hit_e_rh;
  wire logic we_e_rl = reg_wr && hit_e_rl;
  wire logic we_e_mc = reg_wr && hit_e_mc;
  wire logic we_e_su = reg_wr && hit_e_su;

  // Odd copies
  wire logic we_o_aw = reg_wr && hit_o_aw;
  wire logic we_o_rh = reg_wr && hit_o_rh;
  wire logic we_o_rl = reg_wr && hit_o_rl;
  wire logic we_o_mc = reg_wr && hit_o_mc;
  wire logic we_o_su = reg_wr && hit_o_su;

  // Shared registers
  wire logic we_lo = reg_wr && hit_lo;
  wire logic we_lg = reg_wr && hit_lg;
  wire logic we_ug = reg_wr && hit_ug;
  wire logic we_vg = reg_wr && hit_vg;

  // Read mux; unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    if (hit_e_aw) begin
      rd_mux = even_regs.active_width_low;
    end else if (hit_e_rh) begin
      rd_mux = even_regs.horiz_ratio_high;
    end else if (hit_e_rl) begin
      rd_mux = even_regs.horiz_ratio_low;
    end else if (hit_e_mc) begin
      rd_mux = even_regs.misc_config;
    end else if (hit_e_su) begin
      rd_mux = even_regs.size_upper_bits;
    end else if (hit_o_aw) begin
      rd_mux = odd_regs.active_width_low;
    end else if (hit_o_rh) begin
      rd_mux = odd_regs.horiz_ratio_high;
    end else if (hit_o_rl) begin
      rd_mux = odd_regs.horiz_ratio_low;
    end else if (hit_o_mc) begin
      rd_mux = odd_regs.misc_config;
    end else if (hit_o_su) begin
      rd_mux = odd_regs.size_upper_bits;
    end else if (hit_lo) begin
      rd_mux = luma_offset;
    end else if (hit_lg) begin
      rd_mux = luma_gain_low;
    end else if (hit_ug) begin
      rd_mux = u_gain_low;
    end else if (hit_vg) begin
      rd_mux = v_gain_low;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  // All bits stored as written, reserved bit 3 too, so readback is exact
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      even_regs.active_width_low <= `VSLC_RST_ACTIVE_WIDTH_LOW; // R1
      even_regs.horiz_ratio_high <= `VSLC_RST_HORIZ_RATIO_HIGH; // R3
      even_regs.horiz_ratio_low <= `VSLC_RST_HORIZ_RATIO_LOW; // R3
      even_regs.misc_config <= `VSLC_RST_MISC_CONFIG; // R13
      even_regs.size_upper_bits <= `VSLC_RST_SIZE_UPPER_BITS;
    end else begin
      if (we_e_aw) even_regs.active_width_low <= reg_wdata; // R18
      if (we_e_rh) even_regs.horiz_ratio_high <= reg_wdata;
      if (we_e_rl) even_regs.horiz_ratio_low <= reg_wdata;
      if (we_e_mc) even_regs.misc_config <= reg_wdata; // R10
      if (we_e_su) even_regs.size_upper_bits <= reg_wdata;
    end
  end

  // Odd-field copies mirror the even ones 0x80 higher
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      odd_regs.active_width_low <= `VSLC_RST_ACTIVE_WIDTH_LOW; // R1
      odd_regs.horiz_ratio_high <= `VSLC_RST_HORIZ_RATIO_HIGH; // R3
      odd_regs.horiz_ratio_low <= `VSLC_RST_HORIZ_RATIO_LOW; // R3
      odd_regs.misc_config <= `VSLC_RST_MISC_CONFIG; // R13
      odd_regs.size_upper_bits <= `VSLC_RST_SIZE_UPPER_BITS;
    end else begin
      if (we_o_aw) odd_regs.active_width_low <= reg_wdata; // R18
      if (we_o_rh) odd_regs.horiz_ratio_high <= reg_wdata;
      if (we_o_rl) odd_regs.horiz_ratio_low <= reg_wdata;
      if (we_o_mc) odd_regs.misc_config <= reg_wdata;
      if (we_o_su) odd_regs.size_upper_bits <= reg_wdata;
    end
  end

  // Shared registers, one copy for both fields
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      luma_offset <= `VSLC_RST_LUMA_OFFSET; // R4
      luma_gain_low <= `VSLC_RST_LUMA_GAIN_LOW;
      u_gain_low <= `VSLC_RST_U_GAIN_LOW;
      v_gain_low <= `VSLC_RST_V_GAIN_LOW;
    end else begin
      if (we_lo) luma_offset <= reg_wdata;
      if (we_lg) luma_gain_low <= reg_wdata;
      if (we_ug) u_gain_low <= reg_wdata;
      if (we_vg) v_gain_low <= reg_wdata;
    end
  end

  // Read data stands only in the cycle after the strobe
  wire logic [7:0] next_reg_rdata = reg_rd ? rd_mux : 8'h00;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata; // R18
    end
  end

  // --------------------------------------------------------------------
  // Field selection and decoded settings
  // --------------------------------------------------------------------
  wire vslc_pkg::vslc_field_regs_type cur = odd_field ? odd_regs
                                                      : even_regs; // R17
  wire logic [7:0] mc = cur.misc_config;
  // Control byte fields of the selected field copy
  wire logic comp_sel = mc[`VSLC_BIT_COMPONENT];
  wire logic notch_off = mc[`VSLC_BIT_NOTCH_DISABLE];
  wire logic decim_off = mc[`VSLC_BIT_LUMA_DECIM_DISABLE];
  wire logic order_inv = mc[`VSLC_BIT_CHROMA_ORDER_INVERT];
  wire logic lg_top = mc[`VSLC_BIT_LUMA_GAIN_TOP];
  wire logic ug_top = mc[`VSLC_BIT_U_GAIN_TOP];
  wire logic vg_top = mc[`VSLC_BIT_V_GAIN_TOP];
  vslc_pkg::vslc_path_cfg_type next_path_cfg;
  always_comb begin
    next_path_cfg.active_width = {cur.size_upper_bits[1:0],
                                  cur.active_width_low}; // R1 R15
    next_path_cfg.horiz_ratio = {cur.horiz_ratio_high,
                                 cur.horiz_ratio_low}; // R3
    // Y/C input also forces the notch out
    next_path_cfg.notch_enable = !notch_off && !comp_sel; // R5 R7
    next_path_cfg.chroma_adc_enable = comp_sel; // R7
    next_path_cfg.luma_decim_enable = !decim_off; // R8
    next_path_cfg.chroma_order_invert = order_inv; // R9
    next_path_cfg.luma_gain = {lg_top, luma_gain_low}; // R11 R14
    next_path_cfg.u_gain = {ug_top, u_gain_low}; // R12
    next_path_cfg.v_gain = {vg_top, v_gain_low}; // R12
  end

  // Registered so the datapath never sees a field switch glitch
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      path_cfg <= '0;
    end else begin
      path_cfg <= next_path_cfg;
    end
  end

  // --------------------------------------------------------------------
  // Luma offset stage
  // --------------------------------------------------------------------
  // Signed add then clamp to 0..255 so overflow never wraps a white to black
  wire logic signed [9:0] luma_ext = $signed({2'b00, luma_in});
  wire logic signed [9:0] offset_ext = $signed({{2{luma_offset[7]}},
                                                 luma_offset});
  wire logic signed [9:0] luma_sum = luma_ext + offset_ext; // R4
  // Bit 9 set means below zero, bit 8 alone means above full scale
  wire logic luma_under = luma_sum[9];
  wire logic luma_over = luma_sum[8];
  wire logic [7:0] next_luma_out = luma_under ? 8'h00
                                 : (luma_over ? 8'hFF : luma_sum[7:0]);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      luma_out <= 8'h00;
      luma_out_valid <= 1'b0;
    end else begin
      if (luma_in_valid) luma_out <= next_luma_out; // R4
      luma_out_valid <= luma_in_valid;
    end
  end

  // --------------------------------------------------------------------
  // Line start marker
  // --------------------------------------------------------------------
  // One-cycle pulse at the falling edge of the line sync; the datapath
  // counts path_cfg.active_width pixels from here
  wire logic sync_fall = sync_prev && !line_sync_pulse;

  // History resets low, the idle level, so reset gives no false edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_prev <= 1'b0;
      line_active_start <= 1'b0;
    end else begin
      sync_prev <= line_sync_pulse;
      line_active_start <= sync_fall; // R16
    end
  end

endmodule

// ---- rtl/vslc_map.svh ----
// Register offsets, reset values and field positions of the luma control bank
`ifndef VSLC_MAP_SVH
`define VSLC_MAP_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define VSLC_ADDR_W 8
`define VSLC_EVEN_ACTIVE_WIDTH_LOW 8'h1C
`define VSLC_EVEN_HORIZ_RATIO_HIGH 8'h20
`define VSLC_EVEN_HORIZ_RATIO_LOW 8'h24
`define VSLC_LUMA_OFFSET 8'h28
`define VSLC_EVEN_MISC_CONFIG 8'h2C
`define VSLC_EVEN_SIZE_UPPER_BITS 8'h0C
`define VSLC_ODD_ACTIVE_WIDTH_LOW 8'h9C
`define VSLC_ODD_HORIZ_RATIO_HIGH 8'hA0
`define VSLC_ODD_HORIZ_RATIO_LOW 8'hA4
`define VSLC_ODD_MISC_CONFIG 8'hAC
`define VSLC_ODD_SIZE_UPPER_BITS 8'h8C
`define VSLC_LUMA_GAIN_LOW 8'h30
`define VSLC_U_GAIN_LOW 8'h34
`define VSLC_V_GAIN_LOW 8'h38

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define VSLC_RST_ACTIVE_WIDTH_LOW 8'h80
`define VSLC_RST_HORIZ_RATIO_HIGH 8'h02
`define VSLC_RST_HORIZ_RATIO_LOW 8'hAC
`define VSLC_RST_LUMA_OFFSET 8'h00
`define VSLC_RST_MISC_CONFIG 8'h20
`define VSLC_RST_SIZE_UPPER_BITS 8'h12
`define VSLC_RST_LUMA_GAIN_LOW 8'hD8
`define VSLC_RST_U_GAIN_LOW 8'hFE
`define VSLC_RST_V_GAIN_LOW 8'hB4

// ----------------------------------------------------------------------
// Misc config fields
// ----------------------------------------------------------------------
`define VSLC_BIT_NOTCH_DISABLE 7
`define VSLC_BIT_COMPONENT 6
`define VSLC_BIT_LUMA_DECIM_DISABLE 5
`define VSLC_BIT_CHROMA_ORDER_INVERT 4
`define VSLC_BIT_LUMA_GAIN_TOP 2
`define VSLC_BIT_U_GAIN_TOP 1
`define VSLC_BIT_V_GAIN_TOP 0

`endif

// ---- rtl/vslc_pkg.sv ----
// Types shared by the luma control bank
package vslc_pkg;

  // One field's copy of the field-specific registers
  typedef struct packed {
    logic [7:0] active_width_low;
    logic [7:0] horiz_ratio_high;
    logic [7:0] horiz_ratio_low;
    logic [7:0] misc_config;
    logic [7:0] size_upper_bits;
  } vslc_field_regs_type;

  // Decoded path settings driven to the datapath
  typedef struct packed {
    logic [9:0] active_width;
    logic [15:0] horiz_ratio;
    logic notch_enable;
    logic chroma_adc_enable;
    logic luma_decim_enable;
    logic chroma_order_invert;
    logic [8:0] luma_gain;
    logic [8:0] u_gain;
    logic [8:0] v_gain;
  } vslc_path_cfg_type;

endpackage

// ---- verif/vslc_regs_properties.sv ----
// Port-level checks of the luma control register bank
`timescale 1ns/10ps
module vslc_regs_properties #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic odd_field,
  input wire logic line_sync_pulse,
  input wire logic [7:0] luma_in,
  input wire logic luma_in_valid,
  input wire logic [7:0] luma_out,
  input wire logic luma_out_valid,
  input wire logic line_active_start,
  input wire vslc_pkg::vslc_path_cfg_type path_cfg
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam vslc_pkg::vslc_path_cfg_type RST_CFG =
    {10'h280, 16'h02AC, 4'h8, 9'h0D8, 9'h0FE, 9'h0B4};
  logic [7:0] offset_seen;

  // Shadow of the shared offset, snooped from bus writes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      offset_seen <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h28) begin
      offset_seen <= reg_wdata;
    end
  end

  // Saturating add, so dark and luma_offset extremes never wrap
  function automatic logic [7:0] clamp(logic [7:0] y, logic [7:0] o);
    logic signed [9:0] s;
    s = $signed({2'b00, y}) + $signed({{2{o[7]}}, o});
    return s < 0 ? 8'h00 : (s > 255 ? 8'hFF : s[7:0]);
  endfunction

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
  a_read_back: assert property (
    reg_wr && reg_addr == 8'h28 ##1 reg_rd && reg_addr == 8'h28
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback wrong");
  a_reset_decode: assert property (
    !$past(nrst) |=> path_cfg == RST_CFG) else $error("reset cfg wrong");
  a_width_even: assert property (
    reg_wr && reg_addr == 8'h1C && !odd_field ##1 !odd_field
    |=> path_cfg.active_width[7:0] == $past(reg_wdata, 2))
    else $error("even width wrong");
  a_ratio_odd: assert property (
    reg_wr && reg_addr == 8'hA4 && odd_field ##1 odd_field
    |=> path_cfg.horiz_ratio[7:0] == $past(reg_wdata, 2))
    else $error("odd ratio wrong");
  a_misc_decode: assert property (
    reg_wr && reg_addr == 8'hAC && odd_field ##1 odd_field |=>
    {path_cfg.notch_enable, path_cfg.chroma_adc_enable,
     path_cfg.luma_decim_enable, path_cfg.chroma_order_invert,
     path_cfg.luma_gain[8], path_cfg.u_gain[8], path_cfg.v_gain[8]} ==
    {!$past(reg_wdata[7], 2) && !$past(reg_wdata[6], 2),
     $past(reg_wdata[6], 2), !$past(reg_wdata[5], 2),
     $past(reg_wdata[4], 2), $past(reg_wdata[2], 2),
     $past(reg_wdata[1], 2), $past(reg_wdata[0], 2)})
    else $error("misc decode wrong");
  a_notch_comp: assert property (
    path_cfg.chroma_adc_enable |-> !path_cfg.notch_enable)
    else $error("notch on with Y/C");
  a_luma_offset: assert property (
    luma_in_valid |=> luma_out_valid &&
    luma_out == clamp($past(luma_in), $past(offset_seen)))
    else $error("luma offset wrong");
  a_line_start: assert property (
    $fell(line_sync_pulse) |=> line_active_start ##1 !line_active_start)
    else $error("line start missing");
  a_start_cause: assert property (
    line_active_start |-> $past(line_sync_pulse, 2) && !$past(line_sync_pulse))
    else $error("line start unprompted");
endmodule

bind vslc_regs vslc_regs_properties #(.ADDR_W(ADDR_W)) u_props (
  .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .odd_field, .line_sync_pulse, .luma_in, .luma_in_valid, .luma_out,
  .luma_out_valid, .line_active_start, .path_cfg);

// ---- verif/testbench.sv ----
// Self-checking bench for the luma control register bank
`timescale 1ns/10ps
module testbench;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic odd_field = 1'b0;
  logic line_sync_pulse = 1'b0;
  logic [7:0] luma_in = 8'h00;
  logic luma_in_valid = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] luma_out;
  logic luma_out_valid;
  logic line_active_start;
  logic rd_seen = 1'b0;
  logic lv_seen = 1'b0;
  vslc_pkg::vslc_path_cfg_type path_cfg;
  logic [7:0] rq[$];
  logic [7:0] lq[$];
  logic [7:0] sh[256];
  logic [31:0] lfsr = 32'h5CE63030;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int starts = 0;
  logic [7:0] amap[14] = '{8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h0C, 8'h9C,
    8'hA0, 8'hA4, 8'hAC, 8'h8C, 8'h30, 8'h34, 8'h38};
  logic [7:0] rmap[14] = '{8'h80, 8'h02, 8'hAC, 8'h00, 8'h20, 8'h12, 8'h80,
    8'h02, 8'hAC, 8'h20, 8'h12, 8'hD8, 8'hFE, 8'hB4};
  logic [7:0] ofs[5] = '{8'h80, 8'hFF, 8'h00, 8'h01, 8'h7F};

  always #2.5 sys_clk = ~sys_clk;

  vslc_regs u_dut (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .odd_field, .line_sync_pulse, .luma_in, .luma_in_valid,
    .luma_out, .luma_out_valid, .line_active_start, .path_cfg);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  // Expected settings of one field, built from the shadow copies
  function automatic vslc_pkg::vslc_path_cfg_type cfg(logic [7:0] o);
    logic [7:0] m;
    m = sh[o + 8'h2C];
    return {sh[o + 8'h0C][1:0], sh[o + 8'h1C], sh[o + 8'h20], sh[o + 8'h24],
      !m[7] && !m[6], m[6], !m[5], m[4], m[2], sh[8'h30], m[1], sh[8'h34],
      m[0], sh[8'h38]};
  endfunction

  function automatic logic [7:0] clampf(logic [7:0] y, logic [7:0] o);
    int s;
    s = int'(y) + int'($signed(o));
    return s < 0 ? 8'h00 : (s > 255 ? 8'hFF : 8'(s));
  endfunction

  task automatic cmp(string what, logic [63:0] exp, logic [63:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Strobes stay up between back-to-back calls; idle drops them
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    sh[a] = d;
    @(posedge sys_clk);
  endtask

  task automatic rd(logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    rq.push_back(sh[a]);
    @(posedge sys_clk);
  endtask

  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Monitor: each result that appears is matched to its oldest note
  always @(posedge sys_clk) begin
    cycles++;
    if (rd_seen) begin
      cmp("read data", rq.pop_front(), reg_rdata);
    end
    if (lv_seen) begin
      cmp("luma out", {lq.pop_front(), 1'b1}, {luma_out, luma_out_valid});
    end
    if (line_active_start) begin
      starts++;
    end
    rd_seen = reg_rd;
    lv_seen = luma_in_valid;
    if (cycles == 2000) begin
      mismatches++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] y;
    foreach (sh[i]) sh[i] = 8'h00;
    foreach (amap[i]) sh[amap[i]] = rmap[i];
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    cmp("reset cfg", cfg(8'h00), path_cfg);
    foreach (amap[i]) rd(amap[i]);
    rd(8'h50);
    idle();
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      foreach (amap[i]) begin
        d = rnd();
        if (amap[i][6:0] == 7'h2C) begin
          d = {2'(k), d[5:4], 1'b0, d[2:0]};
        end
        wr(amap[i], d);
        rd(amap[i]);
      end
      odd_field <= 1'b0;
      repeat (2) idle();
      cmp("even cfg", cfg(8'h00), path_cfg);
      odd_field <= 1'b1;
      repeat (2) idle();
      cmp("odd cfg", cfg(8'h80), path_cfg);
    end
    $display("test field copies done");
    foreach (ofs[j]) begin
      wr(8'h28, ofs[j]);
      idle();
      for (int n = 0; n < 6; n++) begin
        y = n == 0 ? 8'h00 : (n == 1 ? 8'hFF : rnd());
        luma_in <= y;
        luma_in_valid <= 1'b1;
        lq.push_back(clampf(y, ofs[j]));
        @(posedge sys_clk);
      end
      luma_in_valid <= 1'b0;
    end
    $display("test luma offset done");
    line_sync_pulse <= 1'b1;
    repeat (4) idle();
    line_sync_pulse <= 1'b0;
    repeat (4) idle();
    cmp("line starts", 64'd1, 64'(starts));
    $display("test line start done");
    give_verdict();
  end
endmodule
